// [core/bcla_pkg.sv]
// Package for the boot configuration latch array: offsets, fields, defaults, types.
package bcla_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [1:0] OFS_PORT_LOW_RESET_DRIVE     = 2'h0;
    localparam logic [1:0] OFS_PORT_HIGH_RESET_DRIVE    = 2'h1;
    localparam logic [1:0] OFS_RESET_PIN_DEBUG_CTRL     = 2'h2;
    localparam logic [1:0] OFS_BOOT_CLOCK_ECC_DEBUG_CFG = 2'h3;
    localparam int         LATCH_BYTES                  = 4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_P15_DRIVE        = 0;
    localparam int POS_DEBUG_ENABLE     = 6;
    localparam int POS_RESET_PIN_SELECT = 7;
    localparam int POS_BOOT_SPEED       = 0;
    localparam int POS_DEBUG_PORT       = 1;
    localparam int POS_ECC_ENABLE       = 3;
    localparam int POS_PHASE_DELAY      = 4;

    // ------------------------------------------------------------
    // Factory defaults
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PORT_LOW_RESET_DRIVE     = 8'h00;
    localparam logic [7:0] RST_PORT_HIGH_RESET_DRIVE    = 8'h00;
    localparam logic [7:0] RST_RESET_PIN_DEBUG_CTRL     = 8'h40;
    localparam logic [7:0] RST_BOOT_CLOCK_ECC_DEBUG_CFG = 8'h0a;

    // ------------------------------------------------------------
    // Boot clock speeds in MHz
    // ------------------------------------------------------------
    localparam int BOOT_CLK_SLOW_MHZ = 12;
    localparam int BOOT_CLK_FAST_MHZ = 48;

    typedef enum logic [1:0] {
        BCLA_DRV_HIZ_ANALOG  = 2'b00,
        BCLA_DRV_HIZ_DIGITAL = 2'b01,
        BCLA_DRV_PULL_UP     = 2'b10,
        BCLA_DRV_PULL_DOWN   = 2'b11
    } bcla_drive_t;

    typedef enum logic [1:0] {
        BCLA_DBG_JTAG5 = 2'b00,
        BCLA_DBG_JTAG4 = 2'b01,
        BCLA_DBG_SWD   = 2'b10,
        BCLA_DBG_OFF   = 2'b11
    } bcla_dbg_port_t;

    typedef enum logic [1:0] {
        BCLA_ST_RESET = 2'b00,
        BCLA_ST_LOAD  = 2'b01,
        BCLA_ST_RUN   = 2'b10
    } bcla_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bcla_bus_req_t;

    typedef struct packed {
        logic [1:0] drive_p15;
        logic [1:0] drive_p12;
        logic [1:0] drive_p6;
        logic [1:0] drive_p5;
        logic [1:0] drive_p4;
        logic [1:0] drive_p3;
        logic [1:0] drive_p2;
        logic [1:0] drive_p1;
        logic [1:0] drive_p0;
        logic       reset_pin_select;
        logic       debug_access_enable;
        logic [1:0] debug_port_select;
        logic       ecc_region_enable;
        logic       boot_clock_speed;
        logic [3:0] digital_clock_phase_delay;
    } bcla_cfg_t;

endpackage : bcla_pkg

// [core/bcla_top.sv]
// Boot configuration latch array: latch storage, register port and reset-time config load.
`timescale 1ns/1ps
// What this block does
// - Four latch bytes, zero to three, persistent.
// - Apply latch contents during reset sequence.
// - Drive codes: analog, digital, pull-up, pull-down.
// - One drive mode per whole port.
// - Byte layout of ports, debug, reset-pin.
// - Reset-pin select: 0 GPIO, 1 reset.
// - Debug enable: 1 allows, 0 blocks access.
// - Boot clock 12 MHz or 48 MHz.
// - Debug port: JTAG5, JTAG4, SWD, off.
// - ECC bit dedicates or frees flash region.
// - Four-bit digital clock phase delay field.
module bcla_top #(
    parameter logic       SMALL_PACKAGE = 1'b0,
    parameter logic [7:0] BYTE0_DEFAULT = bcla_pkg::RST_PORT_LOW_RESET_DRIVE,
    parameter logic [7:0] BYTE1_DEFAULT = bcla_pkg::RST_PORT_HIGH_RESET_DRIVE,
    parameter logic [7:0] BYTE3_DEFAULT = bcla_pkg::RST_BOOT_CLOCK_ECC_DEBUG_CFG
) (
    // Clock and reset
    input  wire logic       CLK_SYS_I,
    input  wire logic       RESETN_I,
    // Register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // Port reset drive modes
    output logic      [1:0] DRIVE_P0_O,
    output logic      [1:0] DRIVE_P1_O,
    output logic      [1:0] DRIVE_P2_O,
    output logic      [1:0] DRIVE_P3_O,
    output logic      [1:0] DRIVE_P4_O,
    output logic      [1:0] DRIVE_P5_O,
    output logic      [1:0] DRIVE_P6_O,
    output logic      [1:0] DRIVE_P12_O,
    output logic      [1:0] DRIVE_P15_O,
    // Reset pin, debug, clock and flash control
    output logic            RESET_PIN_SELECT_O,
    output logic            DEBUG_ACCESS_ENABLE_O,
    output logic      [1:0] DEBUG_PORT_SELECT_O,
    output logic            BOOT_CLOCK_FAST_O,
    output logic            ECC_REGION_ENABLE_O,
    output logic      [3:0] DIGITAL_CLOCK_PHASE_DELAY_O,
    output logic            CONFIG_VALID_O
);

    // ------------------------------------------------------------
    // Latch storage
    // ------------------------------------------------------------
    // Storage has no reset: nonvolatile contents must survive a system reset.
    // The initial values stand in for the factory programming.
    localparam logic [7:0] BYTE2_DEFAULT = bcla_pkg::RST_RESET_PIN_DEBUG_CTRL
                                         | {SMALL_PACKAGE, 7'h00};

    bcla_pkg::bcla_bus_req_t req;
    logic [7:0]              latch [bcla_pkg::LATCH_BYTES] = '{BYTE0_DEFAULT, BYTE1_DEFAULT,
                                                              BYTE2_DEFAULT, BYTE3_DEFAULT};
    logic [7:0]              next_latch [bcla_pkg::LATCH_BYTES];
    logic                    addr_hit;
    logic [1:0]              idx;

    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign addr_hit = (req.addr[7:2] == 6'h00);
    assign idx = req.addr[1:0];

    always_comb begin
        for (int i = 0; i < bcla_pkg::LATCH_BYTES; i++) begin
            next_latch[i] = latch[i];
        end
        if (req.wr && addr_hit) begin
            // Each write wears the cells, so the block never writes on its own.
            next_latch[idx] = req.wdata;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        for (int i = 0; i < bcla_pkg::LATCH_BYTES; i++) begin
            latch[i] <= next_latch[i];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    // Idle and unmapped cycles read zero, so a stale byte never leaks out.
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd && addr_hit) begin
            next_rdata = latch[idx];
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign RDATA_O = rdata;

    // ------------------------------------------------------------
    // Load sequence
    // ------------------------------------------------------------
    // The decode is captured on the second edge after reset release, so a write in the
    // same cycle cannot tear the snapshot.
    bcla_pkg::bcla_state_t state;
    bcla_pkg::bcla_state_t next_state;
    bcla_pkg::bcla_cfg_t   cfg;
    bcla_pkg::bcla_cfg_t   next_cfg;
    logic                  valid;
    logic                  next_valid;

    always_comb begin
        next_state = state;
        next_cfg   = cfg;
        next_valid = valid;
        unique case (state)
            bcla_pkg::BCLA_ST_RESET: begin
                next_state = bcla_pkg::BCLA_ST_LOAD;
            end
            bcla_pkg::BCLA_ST_LOAD: begin
                // Each two-bit code covers all pins of its port.
                next_cfg.drive_p0  = latch[0][1:0];
                next_cfg.drive_p1  = latch[0][3:2];
                next_cfg.drive_p2  = latch[0][5:4];
                next_cfg.drive_p3  = latch[0][7:6];
                next_cfg.drive_p4  = latch[1][1:0];
                next_cfg.drive_p5  = latch[1][3:2];
                next_cfg.drive_p6  = latch[1][5:4];
                next_cfg.drive_p12 = latch[1][7:6];
                next_cfg.drive_p15 = latch[2][bcla_pkg::POS_P15_DRIVE +: 2];
                next_cfg.reset_pin_select =
                    latch[2][bcla_pkg::POS_RESET_PIN_SELECT];
                next_cfg.debug_access_enable =
                    latch[2][bcla_pkg::POS_DEBUG_ENABLE];
                next_cfg.boot_clock_speed =
                    latch[3][bcla_pkg::POS_BOOT_SPEED];
                next_cfg.debug_port_select =
                    latch[3][bcla_pkg::POS_DEBUG_PORT +: 2];
                next_cfg.ecc_region_enable =
                    latch[3][bcla_pkg::POS_ECC_ENABLE];
                next_cfg.digital_clock_phase_delay =
                    latch[3][bcla_pkg::POS_PHASE_DELAY +: 4];
                next_valid = 1'b1;
                next_state = bcla_pkg::BCLA_ST_RUN;
            end
            bcla_pkg::BCLA_ST_RUN: begin
                next_state = bcla_pkg::BCLA_ST_RUN;
            end
            default: begin
                next_state = bcla_pkg::BCLA_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            state <= bcla_pkg::BCLA_ST_RESET;
            // Reset values keep debug shut and ports floating until the snapshot lands.
            cfg   <= '{drive_p0:                  2'h0,
                       drive_p1:                  2'h0,
                       drive_p2:                  2'h0,
                       drive_p3:                  2'h0,
                       drive_p4:                  2'h0,
                       drive_p5:                  2'h0,
                       drive_p6:                  2'h0,
                       drive_p12:                 2'h0,
                       drive_p15:                 2'h0,
                       reset_pin_select:          1'b0,
                       debug_access_enable:       1'b0,
                       debug_port_select:         2'h3,
                       ecc_region_enable:         1'b1,
                       boot_clock_speed:          1'b0,
                       digital_clock_phase_delay: 4'h0};
            valid <= 1'b0;
        end else begin
            state <= next_state;
            cfg   <= next_cfg;
            valid <= next_valid;
        end
    end

    assign DRIVE_P0_O                  = cfg.drive_p0;
    assign DRIVE_P1_O                  = cfg.drive_p1;
    assign DRIVE_P2_O                  = cfg.drive_p2;
    assign DRIVE_P3_O                  = cfg.drive_p3;
    assign DRIVE_P4_O                  = cfg.drive_p4;
    assign DRIVE_P5_O                  = cfg.drive_p5;
    assign DRIVE_P6_O                  = cfg.drive_p6;
    assign DRIVE_P12_O                 = cfg.drive_p12;
    assign DRIVE_P15_O                 = cfg.drive_p15;
    assign RESET_PIN_SELECT_O          = cfg.reset_pin_select;
    assign DEBUG_ACCESS_ENABLE_O       = cfg.debug_access_enable;
    assign DEBUG_PORT_SELECT_O         = cfg.debug_port_select;
    assign BOOT_CLOCK_FAST_O           = cfg.boot_clock_speed;
    assign ECC_REGION_ENABLE_O         = cfg.ecc_region_enable;
    assign DIGITAL_CLOCK_PHASE_DELAY_O = cfg.digital_clock_phase_delay;
    assign CONFIG_VALID_O              = valid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_READ_DATA: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        RD_I && ADDR_I[7:2] == 6'h00 && !$past(!RESETN_I)
        |=> RDATA_O == $past(latch[ADDR_I[1:0]]))
        else $error("Read data does not match latch byte.");

    AST_VALID_TIMING: assert property (@(posedge CLK_SYS_I)
        $rose(RESETN_I) |-> !CONFIG_VALID_O ##1 !CONFIG_VALID_O ##1 CONFIG_VALID_O)
        else $error("Configuration not applied two edges after release.");

    AST_P0_DRIVE: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> DRIVE_P0_O == $past(latch[0][1:0]))
        else $error("Port 0 drive mode mismatch.");

    AST_P12_DRIVE: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> DRIVE_P12_O == $past(latch[1][7:6])
            && DRIVE_P15_O == $past(latch[2][1:0]))
        else $error("Port 12 or 15 drive mode mismatch.");

    AST_RESET_PIN: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> RESET_PIN_SELECT_O == $past(latch[2][7]))
        else $error("Reset pin select mismatch.");

    AST_DEBUG_EN: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> DEBUG_ACCESS_ENABLE_O == $past(latch[2][6]))
        else $error("Debug enable mismatch.");

    AST_BYTE3: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> {DIGITAL_CLOCK_PHASE_DELAY_O, ECC_REGION_ENABLE_O,
            DEBUG_PORT_SELECT_O, BOOT_CLOCK_FAST_O} == $past(latch[3]))
        else $error("Byte 3 decode mismatch.");

    AST_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        CONFIG_VALID_O ##1 CONFIG_VALID_O |-> $stable(cfg))
        else $error("Configuration changed after load.");

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // A small counter marks the load point, so no check needs a long delay.
    // It saturates at three; nothing in the block is timed beyond the load.
    logic [1:0] since_release;
    logic [1:0] next_since_release;

    always_comb begin
        next_since_release = since_release;
        if (since_release != 2'h3) begin
            next_since_release = since_release + 2'h1;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            since_release <= 2'h0;
        end else begin
            since_release <= next_since_release;
        end
    end

    // ------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------
    // Storage checks run through reset too, since the latches ignore it.
    AST_WRITE_LANDS: assert property (@(posedge CLK_SYS_I)
        WR_I && ADDR_I[7:2] == 6'h00 |=> latch[$past(ADDR_I[1:0])] == $past(WDATA_I))
        else $error("Mapped write did not land in its latch byte.");

    AST_WRITE_UNMAPPED: assert property (@(posedge CLK_SYS_I)
        WR_I && ADDR_I[7:2] != 6'h00 |=> latch[0] == $past(latch[0])
            && latch[1] == $past(latch[1]) && latch[2] == $past(latch[2])
            && latch[3] == $past(latch[3]))
        else $error("Unmapped write changed a latch byte.");

    AST_READ_IDLE: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        !RD_I |=> RDATA_O == 8'h00)
        else $error("Read data not zero after an idle cycle.");

    AST_READ_UNMAPPED: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        RD_I && ADDR_I[7:2] != 6'h00 |=> RDATA_O == 8'h00)
        else $error("Unmapped read returned nonzero data.");

    // ------------------------------------------------------------
    // Load point checks
    // ------------------------------------------------------------
    AST_RESET_OUTPUTS: assert property (@(posedge CLK_SYS_I)
        !RESETN_I |=> !CONFIG_VALID_O && DEBUG_PORT_SELECT_O == 2'h3 && ECC_REGION_ENABLE_O
            && !DEBUG_ACCESS_ENABLE_O && DRIVE_P0_O == 2'h0 && RDATA_O == 8'h00)
        else $error("Outputs not at their reset values.");

    AST_VALID_LEVEL: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        CONFIG_VALID_O == (since_release >= 2'h2))
        else $error("Valid flag does not follow the load point.");

    AST_LOAD_POINT: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        (state == bcla_pkg::BCLA_ST_LOAD) == (since_release == 2'h1))
        else $error("Snapshot not taken exactly once after release.");

    AST_VALID_STAYS: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        CONFIG_VALID_O |=> CONFIG_VALID_O)
        else $error("Valid flag dropped without a reset.");

    AST_STATE_LEGAL: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state inside {bcla_pkg::BCLA_ST_RESET, bcla_pkg::BCLA_ST_LOAD, bcla_pkg::BCLA_ST_RUN})
        else $error("Load sequencer in an illegal state.");

    // ------------------------------------------------------------
    // Decode checks
    // ------------------------------------------------------------
    // One two-bit code per port; a per-pin mode cannot exist in this decode.
    AST_P1_P3: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> {DRIVE_P3_O, DRIVE_P2_O, DRIVE_P1_O} == $past(latch[0][7:2]))
        else $error("Ports 1 to 3 drive mode mismatch.");

    AST_P4_P6: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> {DRIVE_P6_O, DRIVE_P5_O, DRIVE_P4_O} == $past(latch[1][5:0]))
        else $error("Ports 4 to 6 drive mode mismatch.");

    AST_BOOT_SPEED: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> BOOT_CLOCK_FAST_O == $past(latch[3][0]))
        else $error("Boot clock speed mismatch.");

    AST_ECC: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> ECC_REGION_ENABLE_O == $past(latch[3][3]))
        else $error("ECC region enable mismatch.");

    AST_PHASE: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        state == bcla_pkg::BCLA_ST_LOAD |=> DIGITAL_CLOCK_PHASE_DELAY_O == $past(latch[3][7:4]))
        else $error("Phase delay code mismatch.");

endmodule : bcla_top

// [verif/bcla_boot_consumer.sv]
// Model of the on-chip boot logic that consumes the decoded configuration.
`timescale 1ns/1ps
module bcla_boot_consumer (
    // Snapshot status
    input  wire logic       valid_i,
    // Decoded configuration
    input  wire logic       fast_i,
    input  wire logic       dbg_en_i,
    input  wire logic [1:0] dbg_port_i,
    // Observed effect
    output int              boot_mhz_o,
    output logic            dbg_open_o
);
    // --------------------------------------------------------
    // Boot clock choice and debug gate
    // --------------------------------------------------------
    // Debug stays shut until the snapshot stands, so a stale latch value never opens it.
    always_comb begin
        boot_mhz_o = fast_i ? bcla_pkg::BOOT_CLK_FAST_MHZ : bcla_pkg::BOOT_CLK_SLOW_MHZ;
        dbg_open_o = valid_i & dbg_en_i & (dbg_port_i != 2'b11);
    end
endmodule : bcla_boot_consumer

// [verif/bcla_top_test.sv]
// Self-checking bench for the boot configuration latch array.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module bcla_top_test;
    logic       clk_sys_i = 1'b0;
    logic       resetn_i  = 1'b0;
    logic [7:0] addr_i    = 8'h00;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic [7:0] rdata_o;
    logic [1:0] drv [9];
    logic       rst_sel, dbg_en, fast, ecc, valid, dbg_open;
    logic [1:0] dbg_port;
    logic [3:0] phase;
    int         boot_mhz;
    int         bad_count = 0;
    int         n_checks  = 0;
    int         cycles    = 0;
    logic [31:0] rows [6] = '{32'h0000_e4e4, 32'h0100_1b1b, 32'h0240_8383,
                              32'h030a_5a5a, 32'h0400_ff00, 32'hff00_7700};
    // --------------------------------------------------------
    // Clock, timeout and instances
    // --------------------------------------------------------
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            results();
        end
    end
    bcla_top u_dut (.CLK_SYS_I(clk_sys_i), .RESETN_I(resetn_i), .ADDR_I(addr_i),
        .WDATA_I(wdata_i), .WR_I(wr_i), .RD_I(rd_i), .RDATA_O(rdata_o),
        .DRIVE_P0_O(drv[0]), .DRIVE_P1_O(drv[1]), .DRIVE_P2_O(drv[2]), .DRIVE_P3_O(drv[3]),
        .DRIVE_P4_O(drv[4]), .DRIVE_P5_O(drv[5]), .DRIVE_P6_O(drv[6]),
        .DRIVE_P12_O(drv[7]), .DRIVE_P15_O(drv[8]), .RESET_PIN_SELECT_O(rst_sel),
        .DEBUG_ACCESS_ENABLE_O(dbg_en), .DEBUG_PORT_SELECT_O(dbg_port),
        .BOOT_CLOCK_FAST_O(fast), .ECC_REGION_ENABLE_O(ecc),
        .DIGITAL_CLOCK_PHASE_DELAY_O(phase), .CONFIG_VALID_O(valid));
    bcla_boot_consumer u_boot (.valid_i(valid), .fast_i(fast), .dbg_en_i(dbg_en),
        .dbg_port_i(dbg_port), .boot_mhz_o(boot_mhz), .dbg_open_o(dbg_open));
    // --------------------------------------------------------
    // Bus and check tasks
    // --------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    // The read data stand for one cycle only, so both that cycle and the next are checked.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1 `CHK(rdata_o, exp)
        @(posedge clk_sys_i);
        #1 `CHK(rdata_o, 8'h00)
        @(posedge clk_sys_i);
    endtask : rd
    task automatic check_cfg(input logic [7:0] b0, b1, b2, b3);
        `CHK({drv[3], drv[2], drv[1], drv[0]}, b0)
        `CHK({drv[7], drv[6], drv[5], drv[4]}, b1)
        `CHK({rst_sel, dbg_en, drv[8]}, {b2[7:6], b2[1:0]})
        `CHK({phase, ecc, dbg_port, fast}, b3)
        `CHK(valid, 1'b1)
        `CHK(boot_mhz, b3[0] ? 48 : 12)
        `CHK(dbg_open, b2[6] & (b3[2:1] != 2'b11))
    endtask : check_cfg
    // Holds reset for 8 cycles, then follows the two-edge load and checks the snapshot.
    task automatic rst(input logic [7:0] b0, b1, b2, b3);
        resetn_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        #1 `CHK({valid, dbg_open, dbg_port, ecc, rdata_o}, 13'h0_700)
        @(posedge clk_sys_i);
        #1 `CHK(valid, 1'b0)
        @(posedge clk_sys_i);
        #1 check_cfg(b0, b1, b2, b3);
        @(posedge clk_sys_i);
    endtask : rst
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        rst(8'h00, 8'h00, 8'h40, 8'h0a);
        foreach (rows[i]) begin
            rd(rows[i][31:24], rows[i][23:16]);
            wr(rows[i][31:24], rows[i][15:8]);
            rd(rows[i][31:24], rows[i][7:0]);
        end
        // Writes after the load must leave the decoded outputs alone.
        #1 check_cfg(8'h00, 8'h00, 8'h40, 8'h0a);
        @(posedge clk_sys_i);
        rst(8'he4, 8'h1b, 8'h83, 8'h5a);
        // Each byte is rewritten only a few times in the whole run.
        for (int i = 0; i < 4; i++) begin
            wr(8'h02, {i[0], ~i[0], 4'h0, i[1:0]});
            wr(8'h03, {4'hf - 4'(i), i[0], i[1:0], i[1]});
            rst(8'he4, 8'h1b, {i[0], ~i[0], 4'h0, i[1:0]}, {4'hf - 4'(i), i[0], i[1:0], i[1]});
        end
        results();
    end
endmodule : bcla_top_test
